// ===== logic/pia_top.sv
// Pulse input point: scan timer, accumulators, daily totals, EU select, alarms, Wishbone
`include "pia_consts.svh"
module pia_top #(
	parameter int unsigned TICKS_PER_SEC = `PIA_SEC_NS / `PIA_CLK_NS,
	parameter int unsigned SEC_PER_HOUR = `PIA_SEC_PER_HOUR
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_pulse,
	input wire logic i_point_fail,
	input wire logic i_limit_trip,
	output pia_pkg::pia_eu_mode_t o_eu_mode,
	output logic [31:0] o_eu_value,
	output logic [2:0] o_alarm,
	output logic o_irq
);
	import pia_pkg::*;

	// ---------------------------------------------
	// Declarations
	// ---------------------------------------------
	logic scan_en, alarm_en, hist_en;
	logic [15:0] scan_period, conv, rate_per, scan_sec;
	logic [31:0] rollover, sec_cnt, hr_sec;
	logic [4:0] contract_hour, hour_now, next_hour;
	logic [31:0] tag_mem [0:2];
	logic [23:0] accum, delta, next_accum;
	logic [31:0] daily, today, yest, rate, next_daily, next_today, next_yest, next_eu;
	logic [31:0] prod, run_total, rd, wv;
	logic [24:0] acc_sum;
	logic [3:0] irq_stat, irq_mask, irq_set;
	logic [1:0] pin_m, pin_s;
	logic [2:0] alarm_now;
	logic sec_tick, scan_tick, hour_tick, day_evt, day_pend, wrap;
	logic wr, take, div_done;
	logic [31:0] quot;
	pia_state_t state;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] pia_merge(input logic [31:0] old, input logic [31:0] dat,
			input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (dat & m);
	endfunction

	// ---------------------------------------------
	// Wishbone slave
	// ---------------------------------------------
	// Write happens on the edge that raises ack
	assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
	assign wv = pia_merge(rd, i_wb_dat, i_wb_sel);

	// Read mux; unmapped words read zero
	always_comb begin
		case (i_wb_adr)
			`PIA_REG_CTRL: rd = {27'h0, hist_en, o_eu_mode, alarm_en, scan_en};
			`PIA_REG_SCAN: rd = {16'h0, scan_period};
			`PIA_REG_CONV: rd = {16'h0, conv};
			`PIA_REG_RPER: rd = {16'h0, rate_per};
			`PIA_REG_ROLL: rd = rollover;
			`PIA_REG_CHOUR: rd = {27'h0, contract_hour};
			`PIA_REG_HOUR: rd = {27'h0, hour_now};
			`PIA_REG_TAG0: rd = tag_mem[0];
			`PIA_REG_TAG0 + 8'h04: rd = tag_mem[1];
			`PIA_REG_TAG0 + 8'h08: rd = tag_mem[2];
			`PIA_REG_ACCUM: rd = {8'h0, accum};
			`PIA_REG_DAILY: rd = daily;
			`PIA_REG_TODAY: rd = today;
			`PIA_REG_YEST: rd = yest;
			`PIA_REG_RATE: rd = rate;
			`PIA_REG_EU: rd = o_eu_value;
			`PIA_REG_ALARM: rd = {29'h0, o_alarm};
			`PIA_REG_ISTAT: rd = {28'h0, irq_stat};
			`PIA_REG_IMASK: rd = {28'h0, irq_mask};
			default: rd = 32'h0;
		endcase
	end

	// Single-cycle ack, dropped the cycle after
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
			o_wb_dat <= rd;
		end
	end

	// Configuration registers
	// default one second scan
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			scan_en <= 1'b1;
			alarm_en <= 1'b0;
			hist_en <= 1'b1;
			o_eu_mode <= PIA_EU_RATE;
			scan_period <= `PIA_SCAN_DEF_S;
			conv <= `PIA_CONV_DEF;
			rate_per <= `PIA_RPER_DEF;
			rollover <= `PIA_ROLL_DEF;
			contract_hour <= 5'h00;
		end else if (wr) begin
			case (i_wb_adr)
				`PIA_REG_CTRL: begin
					scan_en <= wv[`PIA_CTRL_SCAN];
					alarm_en <= wv[`PIA_CTRL_ALM];
					o_eu_mode <= pia_eu_mode_t'(wv[`PIA_CTRL_MODE +: 2]);
					hist_en <= wv[`PIA_CTRL_HIST];
				end
				`PIA_REG_SCAN: scan_period <= wv[15:0];
				`PIA_REG_CONV: conv <= wv[15:0];
				`PIA_REG_RPER: rate_per <= wv[15:0];
				`PIA_REG_ROLL: rollover <= wv;
				`PIA_REG_CHOUR: contract_hour <= wv[4:0];
				default: ;
			endcase
		end
	end

	// Point identifier, ten characters over three words
	// identifier storage
	for (genvar gi = 0; gi < 3; gi++) begin : g_tag
		always_ff @(posedge i_mclk) begin
			if (i_rst) begin
				tag_mem[gi] <= 32'h0;
			end else if (wr && i_wb_adr == `PIA_REG_TAG0 + 8'(4 * gi)) begin
				tag_mem[gi] <= (gi == 2) ? (wv & `PIA_TAG_LAST_MASK) : wv;
			end
		end
	end

	// ---------------------------------------------
	// Scan and hour timers
	// ---------------------------------------------
	// one-second prescaler drives scans
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sec_cnt <= 32'h0;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= (sec_cnt == 32'(TICKS_PER_SEC - 1));
			sec_cnt <= (sec_cnt == 32'(TICKS_PER_SEC - 1)) ? 32'h0 : sec_cnt + 32'h1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			scan_sec <= 16'h0;
			scan_tick <= 1'b0;
		end else begin
			scan_tick <= 1'b0;
			if (!scan_en) begin
				scan_sec <= 16'h0;
			end else if (sec_tick) begin
				if ({1'b0, scan_sec} + 17'h1 >= {1'b0, scan_period}) begin
					scan_sec <= 16'h0;
					scan_tick <= 1'b1;
				end else begin
					scan_sec <= scan_sec + 16'h1;
				end
			end
		end
	end

	assign hour_tick = sec_tick && hr_sec == 32'(SEC_PER_HOUR - 1);
	assign next_hour = (hour_now == `PIA_LAST_HOUR) ? 5'h00 : hour_now + 5'h01;

	// contract hour opens the new day
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			hr_sec <= 32'h0;
			hour_now <= 5'h00;
			day_evt <= 1'b0;
		end else begin
			day_evt <= hour_tick && next_hour == contract_hour;
			if (wr && i_wb_adr == `PIA_REG_HOUR) begin
				hour_now <= wv[4:0];
				hr_sec <= 32'h0;
			end else if (hour_tick) begin
				hour_now <= next_hour;
				hr_sec <= 32'h0;
			end else if (sec_tick) begin
				hr_sec <= hr_sec + 32'h1;
			end
		end
	end

	// Turnover waits for the next completed scan; a new event beats the consume
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			day_pend <= 1'b0;
		end else begin
			day_pend <= day_evt | (day_pend & ~(state == ST_UPD));
		end
	end

	// ---------------------------------------------
	// Scan pipeline
	// ---------------------------------------------
	assign take = (state == ST_IDLE) && scan_tick;

	pia_edge #(.W(24)) u_edge (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_pin(i_pulse),
		.i_take(take),
		.o_count(delta)
	);

	// rate division by the rate period
	pia_div #(.W(32)) u_div (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_start(state == ST_MUL),
		.i_num(prod),
		.i_den({16'h0, rate_per}),
		.o_done(div_done),
		.o_quot(quot)
	);

	// Sequencer; a tick during a busy scan is dropped, the counts are kept
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: state <= scan_tick ? ST_MUL : ST_IDLE;
				ST_MUL: state <= ST_DIV;
				ST_DIV: state <= div_done ? ST_UPD : ST_DIV;
				ST_UPD: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Next values of the totals
	always_comb begin
		prod = 32'(delta * conv);
		acc_sum = {1'b0, accum} + {1'b0, delta};
		wrap = acc_sum >= {1'b0, `PIA_ACC_WRAP};
		next_accum = wrap ? 24'(acc_sum - {1'b0, `PIA_ACC_WRAP}) : acc_sum[23:0];
		next_daily = (day_pend && hist_en) ? 32'h0 : daily + {8'h0, delta};
		next_yest = day_pend ? today + prod : yest;
		next_today = day_pend ? 32'h0 : today + prod;
		run_total = 32'(next_accum * conv);
		case (o_eu_mode)
			PIA_EU_RATE: next_eu = quot;
			PIA_EU_TODAY: next_eu = next_today;
			PIA_EU_RUN: next_eu = (run_total >= rollover) ? 32'h0 : run_total;
			default: next_eu = quot;
		endcase
	end

	// all values move together at scan end
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			accum <= 24'h0;
			daily <= 32'h0;
			today <= 32'h0;
			yest <= 32'h0;
			rate <= 32'h0;
			o_eu_value <= 32'h0;
		end else if (state == ST_UPD) begin
			accum <= next_accum;
			daily <= next_daily;
			today <= next_today;
			yest <= next_yest;
			rate <= quot;
			o_eu_value <= next_eu;
		end else if (wr && i_wb_adr == `PIA_REG_EU && !scan_en) begin
			o_eu_value <= wv;
		end
	end

	// ---------------------------------------------
	// Alarms and interrupt
	// ---------------------------------------------
	// Level inputs pass two stages first
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pin_m <= 2'b00;
			pin_s <= 2'b00;
		end else begin
			pin_m <= {i_limit_trip, i_point_fail};
			pin_s <= pin_m;
		end
	end

	// limit alarm gated, others always shown
	assign alarm_now = {pin_s[1] & alarm_en, ~scan_en, pin_s[0]};

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_alarm <= 3'h0;
		end else begin
			o_alarm <= alarm_now;
		end
	end

	always_comb begin
		irq_set = 4'h0;
		irq_set[`PIA_IRQ_SCAN] = state == ST_UPD;
		irq_set[`PIA_IRQ_DAY] = state == ST_UPD && day_pend;
		irq_set[`PIA_IRQ_WRAP] = state == ST_UPD && wrap;
		irq_set[`PIA_IRQ_ALARM] = |(alarm_now & ~o_alarm);
	end

	// Write one to clear; a same-cycle event wins
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
			o_irq <= 1'b0;
		end else begin
			if (wr && i_wb_adr == `PIA_REG_ISTAT) begin
				irq_stat <= (irq_stat & ~(i_wb_dat[3:0] & {4{i_wb_sel[0]}})) | irq_set;
			end else begin
				irq_stat <= irq_stat | irq_set;
			end
			if (wr && i_wb_adr == `PIA_REG_IMASK) begin
				irq_mask <= wv[3:0];
			end
			o_irq <= |(irq_stat & irq_mask);
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	chk_scan_default: assert property (
		$past(i_rst) |-> scan_period == `PIA_SCAN_DEF_S && scan_en)
		else $error("scan period not one second after reset");
	chk_accum_add: assert property (
		(state == ST_UPD && !wrap) |=> accum == $past(accum) + $past(delta))
		else $error("accumulator missed scan pulses");
	chk_accum_wrap: assert property (
		accum < `PIA_ACC_WRAP)
		else $error("accumulator reached wrap limit");
	chk_update_only: assert property (
		($changed(accum) || $changed(today) || $changed(rate)) |-> $past(state) == ST_UPD)
		else $error("totals changed outside scan end");
	chk_daily_keep: assert property (
		(state == ST_UPD && day_pend && !hist_en) |=> daily == $past(daily) + {8'h0, $past(delta)})
		else $error("daily pulses cleared without history");
	chk_day_capture: assert property (
		(state == ST_UPD && day_pend) |=> today == 32'h0 && yest == $past(today) + $past(prod))
		else $error("yesterday capture or today clear wrong");
	chk_eu_rate: assert property (
		(state == ST_UPD && o_eu_mode == PIA_EU_RATE) |=> o_eu_value == rate)
		else $error("rate mode EU differs from rate");
	chk_roll_zero: assert property (
		(state == ST_UPD && o_eu_mode == PIA_EU_RUN) |=> (o_eu_value == 32'h0 || o_eu_value < rollover))
		else $error("running total not rolled over");
	chk_limit_gate: assert property (
		$past(!alarm_en) |-> !o_alarm[`PIA_ALM_LIMIT] && (o_alarm[`PIA_ALM_MANUAL] == $past(!scan_en)))
		else $error("alarm gating wrong");
	chk_scan_flow: assert property (
		scan_tick && state == ST_IDLE |=> state == ST_MUL ##1 state == ST_DIV ##[1:40] state == ST_UPD)
		else $error("scan pipeline stalled");

	cov_scan: cover property (state == ST_UPD);
	cov_day: cover property (state == ST_UPD && day_pend);
	cov_wrap: cover property (state == ST_UPD && wrap);
	cov_irq: cover property ($rose(o_irq));
endmodule

// ===== logic/pia_consts.svh
// Register map, field positions, reset values and timing constants of the accumulator
`ifndef PIA_CONSTS_SVH
`define PIA_CONSTS_SVH

// ---------------------------------------------
// Register byte offsets
// ---------------------------------------------
`define PIA_REG_CTRL 8'h00
`define PIA_REG_SCAN 8'h04
`define PIA_REG_CONV 8'h08
`define PIA_REG_RPER 8'h0c
`define PIA_REG_ROLL 8'h10
`define PIA_REG_CHOUR 8'h14
`define PIA_REG_HOUR 8'h18
`define PIA_REG_TAG0 8'h20
`define PIA_REG_ACCUM 8'h30
`define PIA_REG_DAILY 8'h34
`define PIA_REG_TODAY 8'h38
`define PIA_REG_YEST 8'h3c
`define PIA_REG_RATE 8'h40
`define PIA_REG_EU 8'h44
`define PIA_REG_ALARM 8'h48
`define PIA_REG_ISTAT 8'h50
`define PIA_REG_IMASK 8'h54

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define PIA_CTRL_SCAN 0
`define PIA_CTRL_ALM 1
`define PIA_CTRL_MODE 2
`define PIA_CTRL_HIST 4
`define PIA_ALM_FAIL 0
`define PIA_ALM_MANUAL 1
`define PIA_ALM_LIMIT 2
`define PIA_IRQ_SCAN 0
`define PIA_IRQ_DAY 1
`define PIA_IRQ_WRAP 2
`define PIA_IRQ_ALARM 3

// ---------------------------------------------
// Reset values and limits
// ---------------------------------------------
`define PIA_SCAN_DEF_S 16'h0001
`define PIA_CONV_DEF 16'h0001
`define PIA_RPER_DEF 16'h0001
`define PIA_ROLL_DEF 32'hffffffff
`define PIA_ACC_WRAP 24'hf42400
`define PIA_TAG_LAST_MASK 32'h0000ffff
`define PIA_LAST_HOUR 5'h17

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define PIA_SEC_NS 1000000000
`define PIA_CLK_NS 5
`define PIA_SEC_PER_HOUR 3600

`endif

// ===== logic/pia_pkg.sv
// Types shared by the pulse input accumulator modules
package pia_pkg;
	typedef enum logic [1:0] {PIA_EU_RATE, PIA_EU_RUN, PIA_EU_TODAY} pia_eu_mode_t;
	typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_DIV, ST_UPD} pia_state_t;
endpackage

// ===== logic/pia_edge.sv
// Meter pin synchroniser and raw edge counter with snapshot
module pia_edge #(
	parameter int unsigned W = 24
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_pin,
	input wire logic i_take,
	output logic [W-1:0] o_count
);
	logic s1, s2, s3;
	logic [W-1:0] cnt;
	logic rise;

	// Two stages before use, third only for edge detection
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= i_pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign rise = s2 & ~s3;

	// Edge in the snapshot cycle starts the new count, so none is lost
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cnt <= '0;
			o_count <= '0;
		end else if (i_take) begin
			o_count <= cnt;
			cnt <= {{(W-1){1'b0}}, rise};
		end else if (rise) begin
			cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ===== logic/pia_div.sv
// Sequential restoring divider, one quotient bit per clock
module pia_div #(
	parameter int unsigned W = 32
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic [W-1:0] i_num,
	input wire logic [W-1:0] i_den,
	output logic o_done,
	output logic [W-1:0] o_quot
);
	localparam int unsigned CW = $clog2(W) + 1;
	logic [W-1:0] rem, den;
	logic [CW-1:0] cnt;
	logic busy;
	logic [W:0] trial;

	// Divide by zero yields all ones, which the caller passes on unchanged as the rate
	always_comb begin
		trial = {rem, o_quot[W-1]} - {1'b0, den};
	end

	// Iteration
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rem <= '0;
			den <= '0;
			cnt <= '0;
			busy <= 1'b0;
			o_done <= 1'b0;
			o_quot <= '0;
		end else if (i_start) begin
			rem <= '0;
			den <= i_den;
			o_quot <= i_num;
			cnt <= CW'(W);
			busy <= 1'b1;
			o_done <= 1'b0;
		end else if (busy) begin
			if (!trial[W]) begin
				rem <= trial[W-1:0];
				o_quot <= {o_quot[W-2:0], 1'b1};
			end else begin
				rem <= {rem[W-2:0], o_quot[W-1]};
				o_quot <= {o_quot[W-2:0], 1'b0};
			end
			cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
			busy <= (cnt != {{(CW-1){1'b0}}, 1'b1});
			o_done <= (cnt == {{(CW-1){1'b0}}, 1'b1});
		end else begin
			o_done <= 1'b0;
		end
	end
endmodule

// ===== testbench/pia_meter.sv
// Field meter model: a burst of square pulses on the pulse pin
module pia_meter (
	input wire logic i_mclk,
	input wire logic i_go,
	input wire logic [7:0] i_count,
	input wire logic [3:0] i_width,
	output logic o_pulse,
	output logic o_busy
);
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------
	// Pulse train
	// ---------------------------------------------
	// ten-plus pulses per scan
	// Width of 2 or more clocks each phase, since the pin is synchronised by two flops
	initial begin
		int n;
		int w;
		o_pulse = 1'b0;
		o_busy = 1'b0;
		forever begin
			@(posedge i_mclk);
			if (i_go === 1'b1) begin
				n = int'(i_count);
				w = (i_width < 4'h2) ? 2 : int'(i_width);
				o_busy <= 1'b1;
				for (int k = 0; k < n; k++) begin
					o_pulse <= 1'b1;
					repeat (w) @(posedge i_mclk);
					o_pulse <= 1'b0;
					repeat (w) @(posedge i_mclk);
				end
				o_busy <= 1'b0;
			end
		end
	end
endmodule

// ===== testbench/pia_top_tb_top.sv
// Self-checking bench for the pulse input accumulator
`include "pia_consts.svh"
module pia_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pia_pkg::*;

	// ---------------------------------------------
	// Signals
	// ---------------------------------------------
	localparam int TPS = 100;
	localparam int SPH = 3;
	localparam logic RD = 1'b0;
	localparam logic WR = 1'b1;
	typedef struct {logic rd; logic [31:0] v;} pia_note_t;
	logic i_mclk = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic pfail = 1'b0, ltrip = 1'b0, go = 1'b0, ack, irq, pulse, busy;
	logic [7:0] adr = 8'h00, cnt = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, euv, acc = 32'h0, daily = 32'h0, today = 32'h0;
	logic [31:0] yest = 32'h0, rate = 32'h0, conv = 32'h1, rper = 32'h1;
	logic [2:0] alm;
	pia_eu_mode_t mode;
	integer seed = 32'ha1434169;
	int failures = 0, checks = 0, cyc_n = 0, t_irq = 0;
	pia_note_t notes[$];
	pia_note_t nt;

	initial forever #2.5 i_mclk = ~i_mclk;

	pia_top #(.TICKS_PER_SEC(TPS), .SEC_PER_HOUR(SPH)) dut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
		.i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_pulse(pulse),
		.i_point_fail(pfail), .i_limit_trip(ltrip), .o_eu_mode(mode), .o_eu_value(euv),
		.o_alarm(alm), .o_irq(irq));
	pia_meter meter (.i_mclk(i_mclk), .i_go(go), .i_count(cnt), .i_width(4'h2),
		.o_pulse(pulse), .o_busy(busy));

	// ---------------------------------------------
	// Tasks
	// ---------------------------------------------
	task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic finish_test();
		if (failures == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// One classic cycle; for a read, d is the expected data noted for the watcher
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= w ? d : 32'h0;
		notes.push_back('{~w, d});
		do @(posedge i_mclk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// Bounded only by the run timeout
	task automatic wait_irq();
		while (irq !== 1'b1) @(posedge i_mclk);
		t_irq = cyc_n;
	endtask

	// Irq needs one edge to fall after the clear lands
	task automatic idle();
		wait_irq();
		wb(WR, `PIA_REG_ISTAT, 32'hf);
		repeat (2) @(posedge i_mclk);
	endtask

	// Pulses start right after a scan completes so all land in the next scan
	task automatic burst(input logic [7:0] n);
		idle();
		wait_irq();
		cnt <= n;
		go <= 1'b1;
		@(posedge i_mclk);
		go <= 1'b0;
		wb(WR, `PIA_REG_ISTAT, 32'hf);
		while (busy !== 1'b0) @(posedge i_mclk);
		wb(RD, `PIA_REG_ACCUM, acc);
		wait_irq();
		acc += 32'(n);
		daily += 32'(n);
		today += 32'(n) * conv;
		rate = 32'(n) * conv / rper;
	endtask

	// ---------------------------------------------
	// Watcher and timeout
	// ---------------------------------------------
	// Each acknowledge retires the oldest note
	always @(posedge i_mclk) begin
		if (ack === 1'b1) begin
			nt = notes.pop_front();
			if (nt.rd) cmp(nt.v, rdat);
		end
	end

	always @(posedge i_mclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 10000) begin
			failures++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, 32'h0, cyc_n);
			finish_test();
		end
	end

	// ---------------------------------------------
	// Sequence
	// ---------------------------------------------
	initial begin
		logic [31:0] e;
		int m;
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		// Defaults, unmapped place, identifier storage
		wb(RD, `PIA_REG_CTRL, 32'h11);
		wb(RD, `PIA_REG_SCAN, 32'h1);
		wb(RD, `PIA_REG_ROLL, 32'hffffffff);
		wb(RD, `PIA_REG_ACCUM, 32'h0);
		wb(WR, 8'h5c, 32'h5a5a5a5a);
		wb(RD, 8'h5c, 32'h0);
		wb(WR, `PIA_REG_TAG0 + 8'h8, 32'hffffffff);
		wb(RD, `PIA_REG_TAG0 + 8'h8, `PIA_TAG_LAST_MASK);
		wb(WR, `PIA_REG_TAG0, 32'h41424344);
		wb(RD, `PIA_REG_TAG0, 32'h41424344);
		wb(WR, `PIA_REG_TAG0 + 8'h4, 32'h45464748);
		wb(RD, `PIA_REG_TAG0 + 8'h4, 32'h45464748);
		wb(WR, `PIA_REG_IMASK, 32'h1);
		// Scan completions spaced by the period register
		wb(WR, `PIA_REG_SCAN, 32'h2);
		idle();
		idle();
		m = t_irq;
		idle();
		cmp(32'(2 * TPS), 32'(t_irq - m));
		wb(WR, `PIA_REG_SCAN, 32'h1);
		// Every output mode with random scaling
		for (m = 0; m < 4; m++) begin
			conv = 32'($unsigned($random(seed)) % 15 + 1);
			rper = 32'($unsigned($random(seed)) % 3 + 1);
			wb(WR, `PIA_REG_CONV, conv);
			wb(WR, `PIA_REG_RPER, rper);
			wb(WR, `PIA_REG_CTRL, 32'h11 | 32'(m << 2));
			burst(8'(10 + $unsigned($random(seed)) % 2));
			e = (m == 1) ? acc * conv : (m == 2) ? today : rate;
			wb(RD, `PIA_REG_ACCUM, acc);
			wb(RD, `PIA_REG_DAILY, daily);
			wb(RD, `PIA_REG_TODAY, today);
			wb(RD, `PIA_REG_RATE, rate);
			wb(RD, `PIA_REG_EU, e);
			cmp(e, euv);
			cmp(32'(m), 32'(mode));
		end
		// Running total at and just below the rollover point
		wb(WR, `PIA_REG_CTRL, 32'h15);
		wb(WR, `PIA_REG_ROLL, acc * conv);
		idle();
		idle();
		wb(RD, `PIA_REG_EU, 32'h0);
		wb(WR, `PIA_REG_ROLL, acc * conv + 32'h1);
		idle();
		idle();
		wb(RD, `PIA_REG_EU, acc * conv);
		// Two day turnovers, history totalizing on then off
		for (m = 0; m < 2; m++) begin
			wb(WR, `PIA_REG_CTRL, (m == 0) ? 32'h11 : 32'h01);
			wb(WR, `PIA_REG_CHOUR, 32'h5);
			wb(WR, `PIA_REG_HOUR, 32'h4);
			repeat (5) idle();
			yest = today;
			today = 32'h0;
			if (m == 0) daily = 32'h0;
			wb(RD, `PIA_REG_YEST, yest);
			wb(RD, `PIA_REG_TODAY, today);
			wb(RD, `PIA_REG_DAILY, daily);
			burst(8'd10);
		end
		// Masked scan event stays off the irq line
		wb(WR, `PIA_REG_IMASK, 32'h0);
		repeat (150) @(posedge i_mclk);
		cmp(32'h0, 32'(irq));
		wb(RD, `PIA_REG_ISTAT, 32'h1);
		// Alarm indicators, scanning stopped, limit alarming off then on
		wb(WR, `PIA_REG_CTRL, 32'h10);
		pfail <= 1'b1;
		ltrip <= 1'b1;
		repeat (6) @(posedge i_mclk);
		wb(RD, `PIA_REG_ALARM, 32'h3);
		wb(WR, `PIA_REG_CTRL, 32'h12);
		wb(RD, `PIA_REG_ALARM, 32'h7);
		cmp(32'h7, 32'(alm));
		wb(WR, `PIA_REG_ISTAT, 32'hf);
		wb(RD, `PIA_REG_ISTAT, 32'h0);
		// Manual value while stopped; read-only total ignores writes
		wb(WR, `PIA_REG_EU, 32'h1234);
		wb(RD, `PIA_REG_EU, 32'h1234);
		wb(WR, `PIA_REG_ACCUM, 32'h0);
		wb(RD, `PIA_REG_ACCUM, acc);
		// Second reset in mid-run
		@(posedge i_mclk);
		i_rst <= 1'b1;
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		wb(RD, `PIA_REG_ACCUM, 32'h0);
		wb(RD, `PIA_REG_YEST, 32'h0);
		wb(RD, `PIA_REG_CTRL, 32'h11);
		cmp(32'h0, 32'(mode));
		finish_test();
	end
endmodule
